/* rtl/ccv_pkg.sv */
// Package with timing counts, codec write table and encodings for the codec configurator.
package ccv_pkg;
    // System clock and two-wire bus timing.
    localparam int CLOCK_HZ          = 10_000_000;
    localparam int QUARTER_NS        = 2500;
    localparam int QUARTER_CYCLES    = (QUARTER_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam int DEBOUNCE_US       = 20_000;
    localparam int DEBOUNCE_CYCLES   = DEBOUNCE_US * (CLOCK_HZ / 1_000_000);

    // Codec bus address, arbitrary value.
    localparam logic [6:0] CODEC_ADDR = 7'h1a;

    // Codec control words: 7-bit register index and 9-bit value.
    localparam logic [6:0] REG_RESET   = 7'h0f;
    localparam logic [6:0] REG_LINE_L  = 7'h00;
    localparam logic [6:0] REG_LINE_R  = 7'h01;
    localparam logic [6:0] REG_GAIN    = 7'h02;
    localparam logic [6:0] REG_PATH    = 7'h04;
    localparam logic [6:0] REG_DIGITAL = 7'h05;
    localparam logic [6:0] REG_POWER   = 7'h06;
    localparam logic [6:0] REG_FORMAT  = 7'h07;
    localparam logic [6:0] REG_RATE    = 7'h08;
    localparam logic [6:0] REG_ACTIVE  = 7'h09;
    localparam logic [8:0] VAL_RESET   = 9'h000;
    localparam logic [8:0] VAL_LINE    = 9'h017;
    localparam logic [8:0] VAL_PATH    = 9'h01c; // Line bypass plus microphone side path to line-out.
    localparam logic [8:0] VAL_DIGITAL = 9'h000;
    localparam logic [8:0] VAL_POWER   = 9'h000;
    localparam logic [8:0] VAL_FORMAT  = 9'h042; // Codec is clock master.
    localparam logic [8:0] VAL_RATE48K = 9'h000; // 48 kHz sample rate.
    localparam logic [8:0] VAL_ACTIVE  = 9'h001;
    localparam logic [8:0] GAIN_BASE   = 9'h05b;
    localparam logic [8:0] GAIN_STEP   = 9'h004;

    localparam logic [3:0] TABLE_LEN   = 4'ha;
    localparam logic [3:0] GAIN_SLOT   = 4'h3;
    localparam logic [3:0] VOL_MAX     = 4'h9;
    localparam logic [4:0] FRAME_LAST  = 5'h1a;

    // Bus sequencer states, Gray along idle, start, shift, stop, gap.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_SHIFT = 3'b011,
        ST_STOP  = 3'b010,
        ST_GAP   = 3'b110
    } ccv_state_t;
endpackage : ccv_pkg

/* rtl/codec_config_volume_stepper.sv */
// Codec configurator: two-wire write sequencer, volume stepping and link clock edge detection.
`timescale 1ns/10ps
`default_nettype none

// How it works
// R1: The codec makes bit and channel clocks; here they are only sampled inputs.
// R2: Sample rate and gain are set only through two-wire bus write transactions.
// R3: The configuration sequence programs a fixed 48 kHz sample rate.
// R4: Configuration mixes line-in with microphone-in and routes the sum to line-out.
// R5: Each button press steps to the next of ten levels; presses during a running write merge into one further gain write.
// R6: Volume index runs zero to nine, steps by one, wraps back to zero.
// R7: Button is debounced and edge-detected; no write starts while one is running.
module codec_config_volume_stepper
    import ccv_pkg::*;
#(
    parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
) (
    input  wire logic       clock,              // System clock, 10 MHz.
    input  wire logic       reset,              // Synchronous reset, active high.
    input  wire logic       volumeStepButtonN,  // Volume button pin, low while pressed.
    input  wire logic       serialBitClock,     // Bit clock from the codec.
    input  wire logic       channelSelectClock, // Channel clock from the codec.
    input  wire logic       sclIn,              // Bus clock pin level (unused, not sampled).
    output logic            sclOut,             // Bus clock drive value, always low.
    output logic            sclOe,              // Pulls bus clock low while high.
    input  wire logic       sdaIn,              // Bus data pin level.
    output logic            sdaOut,             // Bus data drive value, always low.
    output logic            sdaOe,              // Pulls bus data low while high.
    output logic            configDone,         // Set once the start-up sequence has finished.
    output logic            busy,               // High while a bus write runs.
    output logic            ackError,           // Sticky: the codec missed an acknowledge.
    output logic [3:0]      volumeLevel,        // Current volume index.
    output logic            bitClockRise,       // One-cycle pulse per bit clock rising edge.
    output logic            channelClockRise    // One-cycle pulse per channel clock rising edge.
);

    // Builds one codec control frame with released acknowledge slots from a table entry.
    function automatic logic [26:0] frameOf(input logic [15:0] entry);
        frameOf = {CODEC_ADDR, 1'b0, 1'b1, entry[15:9], entry[8], 1'b1, entry[7:0], 1'b1};
    endfunction : frameOf

    // Start-up table; the gain slot takes the current volume.
    function automatic logic [15:0] tableEntry(input logic [3:0] idx, input logic [3:0] vol);
        case (idx)
            4'h0:    tableEntry = {REG_RESET, VAL_RESET};
            4'h1:    tableEntry = {REG_LINE_L, VAL_LINE};
            4'h2:    tableEntry = {REG_LINE_R, VAL_LINE};
            4'h3:    tableEntry = {REG_GAIN, 9'(GAIN_BASE + GAIN_STEP * vol)}; // R5
            4'h4:    tableEntry = {REG_PATH, VAL_PATH}; // R4
            4'h5:    tableEntry = {REG_DIGITAL, VAL_DIGITAL};
            4'h6:    tableEntry = {REG_POWER, VAL_POWER};
            4'h7:    tableEntry = {REG_FORMAT, VAL_FORMAT}; // R1
            4'h8:    tableEntry = {REG_RATE, VAL_RATE48K}; // R3
            default: tableEntry = {REG_ACTIVE, VAL_ACTIVE};
        endcase
    endfunction : tableEntry

    // Synchronisers: stage one feeds stage two only.
    logic [2:0] syncA, syncB, prevB;
    logic       sdaSyncA, sdaSyncB;
    logic       stableButton;
    logic       next_stableButton;
    logic [$clog2(DEBOUNCE_LEN + 1):0] debCount, next_debCount;

    // Sequencer state.
    ccv_state_t state, next_state;
    logic [7:0]  quarterCount, next_quarterCount;
    logic [1:0]  phase, next_phase;
    logic [4:0]  bitCount, next_bitCount;
    logic [26:0] frame, next_frame;
    logic [3:0]  cursor, next_cursor;
    logic        next_configDone, pending, next_pending;
    logic        next_ackError, next_sclOe, next_sdaOe;
    logic [3:0]  next_volumeLevel;
    logic        quarterTick, pressEvent;

    // Pins from outside pass two flops before any use; codec clocks are inputs only.
    always_ff @(posedge clock) begin
        if (reset) begin
            syncA    <= 3'h7;
            syncB    <= 3'h7;
            prevB    <= 3'h7;
            sdaSyncA <= 1'b1;
            sdaSyncB <= 1'b1;
        end else begin
            syncA    <= {volumeStepButtonN, serialBitClock, channelSelectClock}; // R1
            syncB    <= syncA;
            prevB    <= syncB;
            sdaSyncA <= sdaIn;
            sdaSyncB <= sdaSyncA;
        end
    end

    assign bitClockRise     = syncB[1] & ~prevB[1];
    assign channelClockRise = syncB[0] & ~prevB[0];

    // Debounce: the button must hold a new level for the full window before it is accepted.
    always_comb begin
        next_stableButton = stableButton;
        next_debCount     = '0;
        if (syncB[2] != stableButton) begin
            next_debCount = debCount + 1'b1;
            if (debCount >= ($bits(debCount))'(DEBOUNCE_LEN - 1)) begin // R7
                next_stableButton = syncB[2];
                next_debCount     = '0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            stableButton <= 1'b1;
            debCount     <= '0;
        end else begin
            stableButton <= next_stableButton;
            debCount     <= next_debCount;
        end
    end

    // One press is the single falling edge of the debounced level.
    assign pressEvent  = stableButton & ~next_stableButton; // R7
    assign quarterTick = (quarterCount == 8'(QUARTER_CYCLES - 1));

    // Sequencer: start-up table first, then a single gain write whenever a press is pending.
    always_comb begin
        next_state        = state;
        next_quarterCount = quarterTick ? 8'h00 : quarterCount + 8'h01;
        next_phase        = phase;
        next_bitCount     = bitCount;
        next_frame        = frame;
        next_cursor       = cursor;
        next_configDone   = configDone;
        next_pending      = pending;
        next_ackError     = ackError;
        next_sclOe        = sclOe;
        next_sdaOe        = sdaOe;
        next_volumeLevel  = volumeLevel;
        if (pressEvent) begin
            next_volumeLevel = (volumeLevel == VOL_MAX) ? 4'h0 : volumeLevel + 4'h1; // R6
            next_pending     = 1'b1; // R5
        end
        if (state == ST_IDLE) begin
            next_quarterCount = 8'h00;
            next_phase        = 2'h0;
            next_sclOe        = 1'b0;
            next_sdaOe        = 1'b0;
            // A press while a write runs stays pending; the gain write follows afterwards.
            if (!configDone || pending) begin // R7
                next_state    = ST_START;
                next_bitCount = 5'h00;
                if (configDone) begin
                    next_cursor  = GAIN_SLOT;
                    next_pending = pressEvent; // Set wins if another press lands now.
                    next_frame   = frameOf(tableEntry(GAIN_SLOT, next_volumeLevel)); // R2
                end else begin
                    next_frame = frameOf(tableEntry(cursor, volumeLevel)); // R2
                end
            end
        end else if (quarterTick) begin
            next_phase = phase + 2'h1;
            case (state)
                ST_START: begin
                    // Data falls while the clock is high.
                    next_sclOe = 1'b0;
                    next_sdaOe = (phase >= 2'h1);
                    if (phase == 2'h3) begin
                        next_state = ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    // Clock is pulled low in quarters 0 and 1 and released in quarters 2 and 3.
                    next_sclOe = (phase == 2'h3) || (phase == 2'h0);
                    if (phase == 2'h0) begin
                        // Slot k drives frame bit k; the first slot must not shift, or the top bit is skipped.
                        next_bitCount = bitCount + 5'h01;
                        if (bitCount == 5'h00) begin
                            next_sdaOe = ~frame[26];
                        end else begin
                            next_frame = {frame[25:0], 1'b1};
                            next_sdaOe = ~frame[25];
                        end
                    end
                    // The count is already one ahead here, so slots 8, 17 and 26 read as 9, 18 and 27.
                    if (phase == 2'h2 && (bitCount == 5'h09 || bitCount == 5'h12 || bitCount == FRAME_LAST + 5'h01)) begin
                        next_ackError = ackError | sdaSyncB;
                    end
                    // Data stays released into the stop so it never moves on the falling clock edge.
                    if (phase == 2'h3 && bitCount == FRAME_LAST + 5'h01) begin
                        next_state = ST_STOP;
                    end
                end
                ST_STOP: begin
                    // Clock rises, then data rises while the clock is high.
                    next_sclOe = (phase == 2'h0);
                    next_sdaOe = (phase != 2'h2);
                    if (phase == 2'h3) begin
                        next_sdaOe = 1'b0;
                        next_state = ST_GAP;
                    end
                end
                ST_GAP: begin
                    next_sclOe = 1'b0;
                    next_sdaOe = 1'b0;
                    if (phase == 2'h3) begin
                        next_state = ST_IDLE;
                        if (!configDone) begin
                            next_cursor     = cursor + 4'h1;
                            next_configDone = (cursor == TABLE_LEN - 4'h1);
                        end
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state        <= ST_IDLE;
            quarterCount <= 8'h00;
            phase        <= 2'h0;
            bitCount     <= 5'h00;
            frame        <= 27'h0;
            cursor       <= 4'h0;
            configDone   <= 1'b0;
            pending      <= 1'b0;
            ackError     <= 1'b0;
            sclOe        <= 1'b0;
            sdaOe        <= 1'b0;
            volumeLevel  <= 4'h0;
        end else begin
            state        <= next_state;
            quarterCount <= next_quarterCount;
            phase        <= next_phase;
            bitCount     <= next_bitCount;
            frame        <= next_frame;
            cursor       <= next_cursor;
            configDone   <= next_configDone;
            pending      <= next_pending;
            ackError     <= next_ackError;
            sclOe        <= next_sclOe;
            sdaOe        <= next_sdaOe;
            volumeLevel  <= next_volumeLevel;
        end
    end

    // Open-drain pins only ever pull low; the bus pull-ups give the high level.
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign busy   = (state != ST_IDLE);

endmodule : codec_config_volume_stepper

`default_nettype wire

/* bench/ccv_monitor.sv */
// Port checker for the codec configurator.
`timescale 1ns/10ps
`default_nettype none
module ccv_monitor
    import ccv_pkg::*;
#(parameter int DEBOUNCE_LEN = 8) (
    input wire logic       clock,             // Clock.
    input wire logic       reset,             // Reset.
    input wire logic       volumeStepButtonN, // Button pin.
    input wire logic       sclOe,             // Clock pull.
    input wire logic       sdaOe,             // Data pull.
    input wire logic       configDone,        // Start-up over.
    input wire logic       busy,              // Write running.
    input wire logic       ackError,          // Missed ack.
    input wire logic [3:0] volumeLevel,       // Volume index.
    input wire logic       bitClockRise       // Bit clock edge.
);
    localparam int WRITE_WAIT = 6500;
    logic [15:0] lowRun;
    logic [15:0] next_lowRun;
    logic [12:0] waitWrite;
    logic [12:0] next_waitWrite;
    logic [3:0]  prevLevel;
    logic        prevBusy;

    // Low run of the raw pin; it saturates so a held button never wraps back to a short run.
    always_comb begin
        next_lowRun = (volumeStepButtonN || reset) ? 16'h0 : lowRun + {15'h0, ~&lowRun};
    end
    // Cycles since the volume changed without a write starting; it saturates instead of wrapping.
    always_comb begin
        next_waitWrite = waitWrite;
        if (reset) begin
            next_waitWrite = 13'h0000;
        end else if (volumeLevel != prevLevel) begin
            next_waitWrite = 13'h0001;
        end else if (busy && !prevBusy) begin
            next_waitWrite = 13'h0000;
        end else if (waitWrite != 13'h0000 && !(&waitWrite)) begin
            next_waitWrite = waitWrite + 13'h0001;
        end
    end
    always_ff @(posedge clock) begin
        lowRun    <= next_lowRun;
        waitWrite <= next_waitWrite;
        prevLevel <= volumeLevel;
        prevBusy  <= busy;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_level_range: assert property (volumeLevel <= VOL_MAX) else $error("level above nine");
    a_level_step: assert property ($changed(volumeLevel) |-> volumeLevel ==
        (($past(volumeLevel) == VOL_MAX) ? 4'h0 : $past(volumeLevel) + 4'h1)) else $error("level skipped");
    a_press_held: assert property ($changed(volumeLevel) |-> lowRun >= DEBOUNCE_LEN) else $error("bounce");
    a_press_write: assert property (waitWrite <= WRITE_WAIT) else $error("no write");
    a_idle_free: assert property (!busy |-> !sclOe && !sdaOe) else $error("bus driven when idle");
    a_clock_high: assert property ($fell(sclOe) |=> !sclOe [*8]) else $error("short clock high");
    a_stop_gap: assert property ($fell(sdaOe) && !sclOe |=> (!sdaOe && !sclOe) [*8]) else $error("no gap");
    a_rise_pulse: assert property (bitClockRise |=> !bitClockRise [*3]) else $error("long pulse");
    a_ack_sticky: assert property (ackError |=> ackError) else $error("flag cleared");
    cover property ($rose(configDone));
    cover property ($changed(volumeLevel) && volumeLevel == 4'h0);
    cover property ($rose(ackError));
endmodule : ccv_monitor

bind codec_config_volume_stepper ccv_monitor #(.DEBOUNCE_LEN(DEBOUNCE_LEN)) u_mon (
    .clock             (clock),
    .reset             (reset),
    .volumeStepButtonN (volumeStepButtonN),
    .sclOe             (sclOe),
    .sdaOe             (sdaOe),
    .configDone        (configDone),
    .busy              (busy),
    .ackError          (ackError),
    .volumeLevel       (volumeLevel),
    .bitClockRise      (bitClockRise)
);
`default_nettype wire

/* bench/ccv_codec_model.sv */
// Behavioural codec: acknowledges bus writes and runs its audio clocks.
`timescale 1ns/10ps
`default_nettype none
module ccv_codec_model (
    input  wire logic   sclIn,                 // Bus clock wire.
    input  wire logic   sdaIn,                 // Bus data wire.
    input  wire logic   ackMiss,               // Withhold acks.
    output logic        sdaPull = 1'b0,        // Pulls data low.
    output logic        serialBitClock = 1'b0, // Audio bit clock.
    output logic        channelSelectClock = 1'b0, // Audio channel clock.
    output logic [7:0]  frameCount = 8'h0,     // Frames taken.
    output logic [7:0]  lastAddr,              // Last address byte.
    output logic [15:0] lastWord               // Last index and value.
);
    // One more than a frame: the stop's own clock pulse shifts in a last bit.
    logic [27:0] shift = 28'h0;
    int          slot = 0;

    // As clock master the codec runs both clocks freely, at exactly 8 and 64 system clock periods after a fixed 37 ns offset.
    initial begin
        #37;
        fork
            forever #400 serialBitClock = ~serialBitClock;
            forever #3200 channelSelectClock = ~channelSelectClock;
        join
    end
    // Start and stop are judged once the clock wire settles, since both wires may move in one step.
    always @(negedge sdaIn) begin
        #1;
        if (sclIn === 1'b1) slot = 0;
    end
    always @(posedge sdaIn) begin
        #1;
        if (sclIn === 1'b1 && slot == 28) begin
            frameCount = frameCount + 8'h1;
            lastAddr = shift[27:20];
            lastWord = {shift[18:11], shift[9:2]};
        end
    end
    always @(posedge sclIn) begin
        shift = {shift[26:0], sdaIn};
        slot = slot + 1;
    end
    // Each byte is acknowledged by holding data low through its ninth slot.
    always @(negedge sclIn) sdaPull <= (slot % 9 == 8) && !ackMiss;
endmodule : ccv_codec_model
`default_nettype wire

/* bench/test_codec_config_volume_stepper.sv */
// Self-checking bench: start-up writes, volume presses, missed acknowledges and link clock edges.
`timescale 1ns/10ps
`default_nettype none
module test_codec_config_volume_stepper;
    import ccv_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        volumeStepButtonN = 1'b1;
    logic        ackMiss = 1'b0;
    logic        serialBitClock, channelSelectClock, sclIn, sdaIn, sclOe, sdaOe, sdaPull, sclOut, sdaOut;
    logic        configDone, busy, ackError, bitClockRise, channelClockRise;
    logic [3:0]  volumeLevel;
    logic [7:0]  frameCount, lastAddr;
    logic [15:0] lastWord;
    int          miscompares = 0;
    int          comparisons = 0;

    always #50 clock = ~clock;
    // Both wires have pull-ups, so whoever pulls low wins.
    assign sclIn = sclOe ? sclOut : 1'b1;
    assign sdaIn = (sdaOe ? sdaOut : 1'b1) & ~sdaPull;
    codec_config_volume_stepper #(.DEBOUNCE_LEN(8)) u_dut (
        .clock(clock), .reset(reset), .volumeStepButtonN(volumeStepButtonN),
        .serialBitClock(serialBitClock), .channelSelectClock(channelSelectClock),
        .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .configDone(configDone), .busy(busy), .ackError(ackError), .volumeLevel(volumeLevel),
        .bitClockRise(bitClockRise), .channelClockRise(channelClockRise)
    );
    ccv_codec_model u_codec (
        .sclIn(sclIn), .sdaIn(sdaIn), .ackMiss(ackMiss), .sdaPull(sdaPull),
        .serialBitClock(serialBitClock), .channelSelectClock(channelSelectClock),
        .frameCount(frameCount), .lastAddr(lastAddr), .lastWord(lastWord)
    );

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("Compared %0d, mismatched %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // Low for the given cycles, then high long enough for the debouncer to settle.
    task automatic press(input int lowCycles);
        volumeStepButtonN <= 1'b0;
        repeat (lowCycles) @(posedge clock);
        volumeStepButtonN <= 1'b1;
        repeat (20) @(posedge clock);
    endtask : press

    task automatic wait_frames(input logic [7:0] target);
        for (int i = 0; i < 40000 && frameCount !== target; i++) @(posedge clock);
        check({8'h0, frameCount}, {8'h0, target});
    endtask : wait_frames

    // Bit clock of 8 cycles and channel clock of 64 give exact pulse counts over 128 cycles.
    task automatic t_link;
        int nb = 0;
        int nc = 0;
        repeat (128) begin
            @(negedge clock);
            nb += int'(bitClockRise === 1'b1);
            nc += int'(channelClockRise === 1'b1);
        end
        check(16'(nb), 16'h10);
        check(16'(nc), 16'h2);
    endtask : t_link

    task automatic t_startup;
        logic [15:0] w [10];
        w = '{{REG_RESET, VAL_RESET}, {REG_LINE_L, VAL_LINE}, {REG_LINE_R, VAL_LINE}, {REG_GAIN, GAIN_BASE},
              {REG_PATH, VAL_PATH}, {REG_DIGITAL, VAL_DIGITAL}, {REG_POWER, VAL_POWER},
              {REG_FORMAT, VAL_FORMAT}, {REG_RATE, VAL_RATE48K}, {REG_ACTIVE, VAL_ACTIVE}};
        for (int k = 0; k < 10; k++) begin
            wait_frames(8'(k + 1));
            check(lastWord, w[k]);
            check({8'h0, lastAddr}, {8'h0, CODEC_ADDR, 1'b0});
        end
        repeat (150) @(posedge clock);
        check({13'h0, ackError, configDone, busy}, 16'h2);
    endtask : t_startup

    task automatic t_press;
        press(20);
        check({12'h0, volumeLevel}, 16'h1);
        wait_frames(8'hb);
        check(lastWord, {REG_GAIN, GAIN_BASE + GAIN_STEP});
    endtask : t_press

    // Presses during a running write pass nine and wrap; they merge into one further write.
    task automatic t_burst;
        for (int n = 0; n < 8; n++) press(20);
        check({12'h0, volumeLevel}, 16'h9);
        press(20);
        check({12'h0, volumeLevel}, 16'h0);
        wait_frames(8'hd);
        check(lastWord, {REG_GAIN, GAIN_BASE});
        press(4);
        repeat (4000) @(posedge clock);
        check({4'h0, volumeLevel, frameCount}, 16'h000d);
    endtask : t_burst

    // Without acknowledges the write still completes, but the sticky flag rises.
    task automatic t_ack_miss;
        ackMiss <= 1'b1;
        press(20);
        wait_frames(8'he);
        ackMiss <= 1'b0;
        check({15'h0, ackError}, 16'h1);
        check(lastWord, {REG_GAIN, GAIN_BASE + GAIN_STEP});
    endtask : t_ack_miss

    initial begin
        repeat (2) @(posedge clock);
        @(negedge clock);
        check({5'h0, sclOut, sdaOut, sclOe, sdaOe, busy, configDone, ackError, volumeLevel}, 16'h0);
        @(posedge clock);
        reset <= 1'b0;
        t_link();
        t_startup();
        t_press();
        t_burst();
        t_ack_miss();
        give_verdict();
    end
    // The run needs about 50000 cycles; this leaves ample margin.
    initial begin
        repeat (90000) @(posedge clock);
        miscompares++;
        give_verdict();
    end
endmodule : test_codec_config_volume_stepper
`default_nettype wire
